// ---- core/dmd_engine.sv ----
`timescale 1ns/100ps
`default_nettype none
module dmd_engine #(
    parameter int NCH = 6
) (
    input  wire logic             clk_sys_i,
    input  wire logic             sys_rst_i,
    // apb slave
    input  wire logic             psel_i,
    input  wire logic             penable_i,
    input  wire logic             pwrite_i,
    input  wire logic [11:0]      paddr_i,
    input  wire logic [31:0]      pwdata_i,
    output logic      [31:0]      prdata_o,
    output logic                  pready_o,
    output logic                  pslverr_o,
    // on-chip access port
    output dmd_pkg::dmd_mem_t     mem_o,
    input  wire logic [15:0]      mem_rdata_i,
    output logic      [NCH-1:0]   done_o
);
    localparam int CW = $clog2(NCH);

    typedef enum logic [2:0] {ST_IDLE, ST_RD, ST_RD_END, ST_WR, ST_WR_END} dmd_state_t;

    logic [7:0]                  cfg_ff [NCH];
    logic [15:0]                 src_ff [NCH];
    logic [15:0]                 dst_ff [NCH];
    logic [15:0]                 cnt_ff [NCH];
    logic [dmd_pkg::PAGE_W-1:0]  spage_ff;
    logic [dmd_pkg::PAGE_W-1:0]  dpage_ff;
    dmd_state_t                  state_ff;
    logic [CW-1:0]               cur_ff;
    logic [CW-1:0]               last_hi_ff;
    logic [CW-1:0]               last_lo_ff;
    logic                        half_ff;
    logic [15:0]                 data_ff;
    dmd_pkg::dmd_target_t        last_tgt_ff;
    dmd_pkg::dmd_mem_t           mem_ff;
    logic [NCH-1:0]              done_ff;
    logic [31:0]                 prdata_ff;
    logic                        pready_ff;
    logic                        pslverr_ff;

    logic [NCH-1:0]              act_hi;
    logic [NCH-1:0]              act_lo;
    logic                        grant_ok;
    logic [CW-1:0]               grant_ch;
    logic                        grant_hi;
    logic                        xfer_end;
    logic                        elem_end;
    logic                        apb_wr;
    logic                        ch_hit;
    logic [CW-1:0]               ch_idx;
    dmd_pkg::dmd_hit_t           src_hit;
    dmd_pkg::dmd_hit_t           dst_hit;

    // serial data window, common to page 00 and data space
    function automatic dmd_pkg::dmd_hit_t low_decode(input logic [15:0] off);
        dmd_pkg::dmd_hit_t h;
        h.tgt = dmd_pkg::TGT_RESERVED;
        h.sel = 4'h0;
        if (off[15:2] == dmd_pkg::SP0_BASE[15:2]) begin
            h.tgt = dmd_pkg::TGT_SERIAL;
            h.sel = {dmd_pkg::SP_PORT0, off[1:0]};
        end else if (off[15:2] == dmd_pkg::SP2_BASE[15:2]) begin
            h.tgt = dmd_pkg::TGT_SERIAL;
            h.sel = {dmd_pkg::SP_PORT2, off[1:0]};
        end else if (off[15:2] == dmd_pkg::SP1_BASE[15:2]) begin
            h.tgt = dmd_pkg::TGT_SERIAL;
            h.sel = {dmd_pkg::SP_PORT1, off[1:0]};
        end
        return h;
    endfunction : low_decode

    // map takes no mode bits at all, so no boot or overlay setting can move it
    function automatic dmd_pkg::dmd_hit_t map_decode(input logic [1:0] sp,
                                                     input logic [dmd_pkg::PAGE_W-1:0] pg,
                                                     input logic [15:0] off);
        dmd_pkg::dmd_hit_t h;
        h.tgt = dmd_pkg::TGT_RESERVED;
        h.sel = 4'h0;
        if (sp == dmd_pkg::SPACE_IO) begin
            h.tgt = dmd_pkg::TGT_FIFO;
        end else if (sp == dmd_pkg::SPACE_DATA) begin
            if (off < dmd_pkg::LOW_END) begin
                h = low_decode(off);
            end else if (off < dmd_pkg::SCRATCH_END) begin
                h.tgt = dmd_pkg::TGT_SCRATCH;
            end else if (off < dmd_pkg::SINGLE1_BASE) begin
                h.tgt = dmd_pkg::TGT_DUAL0;
            end else if (off < dmd_pkg::UPPER_BASE) begin
                h.tgt = dmd_pkg::TGT_SINGLE1;
            end else begin
                h.tgt = dmd_pkg::TGT_SINGLE2;
            end
        end else if (sp == dmd_pkg::SPACE_PROG && pg <= dmd_pkg::PAGE_3) begin
            if (off < dmd_pkg::LOW_END) begin
                if (pg == dmd_pkg::PAGE_0) begin
                    h = low_decode(off);
                end
            end else if (off < dmd_pkg::SINGLE1_BASE) begin
                h.tgt = dmd_pkg::TGT_DUAL0;
            end else if (off < dmd_pkg::UPPER_BASE) begin
                h.tgt = dmd_pkg::TGT_SINGLE1;
            end else if (pg == dmd_pkg::PAGE_0) begin
                h.tgt = dmd_pkg::TGT_SINGLE2;
            end else if (pg == dmd_pkg::PAGE_1) begin
                h.tgt = dmd_pkg::TGT_SINGLE3;
            end else if (pg == dmd_pkg::PAGE_2 && off >= dmd_pkg::SINGLE4_BASE) begin
                h.tgt = dmd_pkg::TGT_SINGLE4;
            end
        end
        return h;
    endfunction : map_decode

    // rotating pick: first set bit after the previous winner
    function automatic logic [CW:0] rr_pick(input logic [NCH-1:0] req, input logic [CW-1:0] last);
        logic [CW:0] r;
        int          k;
        r = '0;
        for (int i = NCH; i >= 1; i--) begin
            k = (int'(last) + i) % NCH;
            if (req[k]) begin
                r = {1'b1, CW'(k)};
            end
        end
        return r;
    endfunction : rr_pick

    // per-channel activity, sampled by the arbiter only while idle; status reads |act_hi at any time
    for (genvar g = 0; g < NCH; g++) begin : g_act
        assign act_hi[g] = cfg_ff[g][dmd_pkg::CFG_EN] & cfg_ff[g][dmd_pkg::CFG_HIGH] & (cnt_ff[g] != 16'h0000);
        assign act_lo[g] = cfg_ff[g][dmd_pkg::CFG_EN] & ~cfg_ff[g][dmd_pkg::CFG_HIGH] & (cnt_ff[g] != 16'h0000);
    end

    // low channels only see the arbiter when the high set is empty
    always_comb begin
        logic [CW:0] ph;
        logic [CW:0] pl;
        ph = rr_pick(act_hi, last_hi_ff);
        pl = rr_pick(act_lo, last_lo_ff);
        grant_hi = |act_hi;
        grant_ok = grant_hi ? ph[CW] : pl[CW];
        grant_ch = grant_hi ? ph[CW-1:0] : pl[CW-1:0];
    end

    // source and destination decode of the channel in flight
    assign src_hit  = map_decode(cfg_ff[cur_ff][dmd_pkg::CFG_SSP +: 2], spage_ff, src_ff[cur_ff]);
    assign dst_hit  = map_decode(cfg_ff[cur_ff][dmd_pkg::CFG_DSP +: 2], dpage_ff, dst_ff[cur_ff]);
    assign xfer_end = (state_ff == ST_WR_END);
    assign elem_end = xfer_end & (~cfg_ff[cur_ff][dmd_pkg::CFG_DWORD] | half_ff);

    // apb decode
    assign apb_wr = psel_i & penable_i & pwrite_i & pready_ff;
    assign ch_hit = (paddr_i[11:8] == dmd_pkg::CH_REGION) && (paddr_i[7:4] < 4'(NCH));
    assign ch_idx = paddr_i[4 +: CW];

    // channel registers; a software write wins over the engine's update
    for (genvar g = 0; g < NCH; g++) begin : g_ch
        always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
            if (sys_rst_i) begin
                cfg_ff[g] <= 8'h00;
                src_ff[g] <= 16'h0000;
                dst_ff[g] <= 16'h0000;
                cnt_ff[g] <= 16'h0000;
            end else if (apb_wr && ch_hit && ch_idx == CW'(g)) begin
                if (paddr_i[3:2] == dmd_pkg::FLD_CFG) begin
                    cfg_ff[g] <= pwrite_i ? pwdata_i[7:0] : cfg_ff[g];
                end else if (paddr_i[3:2] == dmd_pkg::FLD_SRC) begin
                    src_ff[g] <= pwdata_i[15:0];
                end else if (paddr_i[3:2] == dmd_pkg::FLD_DST) begin
                    dst_ff[g] <= pwdata_i[15:0];
                end else begin
                    cnt_ff[g] <= pwdata_i[15:0];
                end
            end else if (xfer_end && cur_ff == CW'(g)) begin
                src_ff[g] <= src_ff[g] + 16'h0001;
                dst_ff[g] <= dst_ff[g] + 16'h0001;
                if (elem_end) begin
                    cnt_ff[g] <= cnt_ff[g] - 16'h0001;
                    if (cnt_ff[g] == 16'h0001) begin
                        cfg_ff[g][dmd_pkg::CFG_EN] <= 1'b0;
                    end
                end
            end
        end
    end

    // page registers never move with the address, so the offset wraps in-page
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            spage_ff <= '0;
            dpage_ff <= '0;
        end else if (apb_wr && paddr_i == dmd_pkg::REG_SRC_PAGE) begin
            spage_ff <= pwdata_i[dmd_pkg::PAGE_W-1:0];
        end else if (apb_wr && paddr_i == dmd_pkg::REG_DST_PAGE) begin
            dpage_ff <= pwdata_i[dmd_pkg::PAGE_W-1:0];
        end
    end

    // apb answer: one wait state, pready registered
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff  <= 32'h0000_0000;
        end else begin
            pready_ff  <= psel_i & penable_i & ~pready_ff;
            pslverr_ff <= 1'b0;
            prdata_ff  <= 32'h0000_0000;
            if (psel_i && penable_i && !pready_ff) begin
                if (paddr_i == dmd_pkg::REG_SRC_PAGE) begin
                    prdata_ff <= 32'(spage_ff);
                end else if (paddr_i == dmd_pkg::REG_DST_PAGE) begin
                    prdata_ff <= 32'(dpage_ff);
                end else if (paddr_i == dmd_pkg::REG_STATUS) begin
                    prdata_ff <= {22'h00_0000, last_tgt_ff, 3'(cur_ff), half_ff,
                                  (state_ff != ST_IDLE), |act_hi};
                end else if (ch_hit && paddr_i[3:2] == dmd_pkg::FLD_CFG) begin
                    prdata_ff <= {24'h00_0000, cfg_ff[ch_idx]};
                end else if (ch_hit && paddr_i[3:2] == dmd_pkg::FLD_SRC) begin
                    prdata_ff <= {16'h0000, src_ff[ch_idx]};
                end else if (ch_hit && paddr_i[3:2] == dmd_pkg::FLD_DST) begin
                    prdata_ff <= {16'h0000, dst_ff[ch_idx]};
                end else if (ch_hit) begin
                    prdata_ff <= {16'h0000, cnt_ff[ch_idx]};
                end else begin
                    pslverr_ff <= 1'b1; // unmapped
                end
            end
        end
    end

    // transfer sequencer: every phase is internal, so always two cycles each
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            state_ff    <= ST_IDLE;
            cur_ff      <= '0;
            last_hi_ff  <= CW'(NCH - 1);
            last_lo_ff  <= CW'(NCH - 1);
            half_ff     <= 1'b0;
            data_ff     <= 16'h0000;
            last_tgt_ff <= dmd_pkg::TGT_RESERVED;
            mem_ff      <= '0;
            done_ff     <= '0;
        end else begin
            mem_ff.req <= 1'b0;
            done_ff    <= '0;
            case (state_ff)
                ST_IDLE: begin
                    half_ff <= 1'b0;
                    if (grant_ok) begin
                        cur_ff   <= grant_ch;
                        state_ff <= ST_RD;
                        if (grant_hi) begin
                            last_hi_ff <= grant_ch;
                        end else begin
                            last_lo_ff <= grant_ch;
                        end
                    end
                end
                ST_RD: begin
                    // reserved source: no cycle issued at all
                    mem_ff.req   <= (src_hit.tgt != dmd_pkg::TGT_RESERVED);
                    mem_ff.we    <= 1'b0;
                    mem_ff.tgt   <= src_hit.tgt;
                    mem_ff.sel   <= src_hit.sel;
                    mem_ff.addr  <= src_ff[cur_ff];
                    last_tgt_ff  <= src_hit.tgt;
                    state_ff     <= ST_RD_END;
                end
                ST_RD_END: begin
                    data_ff  <= mem_ff.req ? mem_rdata_i : 16'h0000;
                    state_ff <= ST_WR;
                end
                ST_WR: begin
                    mem_ff.req   <= (dst_hit.tgt != dmd_pkg::TGT_RESERVED);
                    mem_ff.we    <= 1'b1;
                    mem_ff.tgt   <= dst_hit.tgt;
                    mem_ff.sel   <= dst_hit.sel;
                    mem_ff.addr  <= dst_ff[cur_ff];
                    mem_ff.wdata <= data_ff;
                    last_tgt_ff  <= dst_hit.tgt;
                    state_ff     <= ST_WR_END;
                end
                ST_WR_END: begin
                    mem_ff.we <= 1'b0;
                    if (elem_end) begin
                        done_ff[cur_ff] <= 1'b1;
                        state_ff        <= ST_IDLE;
                    end else begin
                        half_ff  <= 1'b1; // second word of a 32-bit element
                        state_ff <= ST_RD;
                    end
                end
                default: begin
                    state_ff <= ST_IDLE;
                end
            endcase
        end
    end

    assign prdata_o  = prdata_ff;
    assign pready_o  = pready_ff;
    assign pslverr_o = pslverr_ff;
    assign mem_o     = mem_ff;
    assign done_o    = done_ff;
endmodule : dmd_engine
`default_nettype wire

// ---- core/dmd_pkg.sv ----
package dmd_pkg;
    typedef enum logic [1:0] {SPACE_PROG, SPACE_DATA, SPACE_IO} dmd_space_t;
    typedef enum logic [3:0] {TGT_RESERVED, TGT_SERIAL, TGT_SCRATCH, TGT_DUAL0, TGT_SINGLE1,
                              TGT_SINGLE2, TGT_SINGLE3, TGT_SINGLE4, TGT_FIFO} dmd_target_t;
    typedef struct packed {
        dmd_target_t tgt;
        logic [3:0]  sel;   // serial: {port, register}
    } dmd_hit_t;
    typedef struct packed {
        logic        req;
        logic        we;
        dmd_target_t tgt;
        logic [3:0]  sel;
        logic [15:0] addr;
        logic [15:0] wdata;
    } dmd_mem_t;
    // map boundaries
    localparam logic [15:0] SP0_BASE     = 16'h0020;
    localparam logic [15:0] SP2_BASE     = 16'h0030;
    localparam logic [15:0] SP1_BASE     = 16'h0040;
    localparam logic [15:0] LOW_END      = 16'h0060;
    localparam logic [15:0] SCRATCH_END  = 16'h0080;
    localparam logic [15:0] SINGLE1_BASE = 16'h4000;
    localparam logic [15:0] UPPER_BASE   = 16'h8000;
    localparam logic [15:0] SINGLE4_BASE = 16'hF000;
    localparam logic [6:0]  PAGE_0       = 7'h00;
    localparam logic [6:0]  PAGE_1       = 7'h01;
    localparam logic [6:0]  PAGE_2       = 7'h02;
    localparam logic [6:0]  PAGE_3       = 7'h03;
    localparam logic [1:0]  SP_PORT0     = 2'h0;
    localparam logic [1:0]  SP_PORT1     = 2'h1;
    localparam logic [1:0]  SP_PORT2     = 2'h2;
    // phase lengths in cpu cycles
    localparam int          READ_CYCLES  = 2;
    localparam int          WRITE_CYCLES = 2;
    // apb register map
    localparam logic [11:0] REG_SRC_PAGE = 12'h000;
    localparam logic [11:0] REG_DST_PAGE = 12'h004;
    localparam logic [11:0] REG_STATUS   = 12'h008;
    localparam logic [3:0]  CH_REGION    = 4'h1;
    localparam logic [1:0]  FLD_CFG      = 2'h0;
    localparam logic [1:0]  FLD_SRC      = 2'h1;
    localparam logic [1:0]  FLD_DST      = 2'h2;
    localparam logic [1:0]  FLD_CNT      = 2'h3;
    // channel config bits
    localparam int          CFG_EN       = 0;
    localparam int          CFG_HIGH     = 1;
    localparam int          CFG_DWORD    = 2;
    localparam int          CFG_SSP      = 4;
    localparam int          CFG_DSP      = 6;
    localparam int          PAGE_W       = 7;
endpackage : dmd_pkg

// ---- core/dmd_top_note.sv ----
`timescale 1ns/100ps

// ---- verif/dmd_engine_assertions.sv ----
`timescale 1ns/100ps
`default_nettype none
module dmd_engine_chk #(
    parameter int NCH = 6
) (
    input wire logic              clk_sys_i,
    input wire logic              sys_rst_i,
    input wire logic              psel_i,
    input wire logic              penable_i,
    input wire logic              pready_o,
    input wire logic              pslverr_o,
    input wire dmd_pkg::dmd_mem_t mem_o,
    input wire logic [NCH-1:0]    done_o
);
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (sys_rst_i);
    // shorthands for the phase and map checks
    logic        rd_req;
    logic [15:0] a;
    assign rd_req = mem_o.req && !mem_o.we;
    assign a      = mem_o.addr;

    a_ready_wait: assert property ($rose(penable_i) && psel_i |-> !pready_o ##1 pready_o)
        else $error("pready not in second access cycle");
    a_ready_pulse: assert property (pready_o |=> !pready_o)
        else $error("pready longer than one cycle");
    a_err_ready: assert property (pslverr_o |-> pready_o && psel_i && penable_i)
        else $error("pslverr outside an answer");
    a_rd_then_wr: assert property (rd_req |=> !mem_o.req ##1 (!mem_o.req || mem_o.we))
        else $error("write phase not two cycles after read");
    a_done_gap: assert property (done_o != '0 |=> (done_o == '0) [*4])
        else $error("elements closer than four cycles plus arbitration");
    a_no_reserved: assert property (mem_o.req |-> mem_o.tgt != dmd_pkg::TGT_RESERVED)
        else $error("bus cycle issued to a reserved region");
    a_serial_map: assert property (mem_o.req && mem_o.tgt == dmd_pkg::TGT_SERIAL |->
        a[15:2] inside {14'h0008, 14'h000C, 14'h0010} && mem_o.sel == {((a[6:4] == 3'h2) ? dmd_pkg::SP_PORT0 :
        (a[6:4] == 3'h3) ? dmd_pkg::SP_PORT2 : dmd_pkg::SP_PORT1), a[1:0]}) else $error("serial select wrong");
    a_scratch_map: assert property (mem_o.req && mem_o.tgt == dmd_pkg::TGT_SCRATCH |->
        a inside {[16'h0060:16'h007F]}) else $error("scratchpad hit out of range");
    a_dual_map: assert property (mem_o.req && mem_o.tgt == dmd_pkg::TGT_DUAL0 |->
        a inside {[16'h0060:16'h3FFF]}) else $error("dual block hit out of range");
    a_upper_map: assert property (mem_o.req && mem_o.tgt inside {dmd_pkg::TGT_SINGLE2, dmd_pkg::TGT_SINGLE3,
        dmd_pkg::TGT_SINGLE4} |->
        a[15] && (mem_o.tgt != dmd_pkg::TGT_SINGLE4 || a[15:12] == 4'hF)) else $error("upper block below 8000");
endmodule : dmd_engine_chk

bind dmd_engine dmd_engine_chk #(.NCH(NCH)) dmd_engine_chk_inst (
    .clk_sys_i (clk_sys_i),
    .sys_rst_i (sys_rst_i),
    .psel_i    (psel_i),
    .penable_i (penable_i),
    .pready_o  (pready_o),
    .pslverr_o (pslverr_o),
    .mem_o     (mem_o),
    .done_o    (done_o)
);
`default_nettype wire

// ---- verif/dmd_mem_model.sv ----
`timescale 1ns/100ps
`default_nettype none
module dmd_mem_model (
    input  wire logic              clk_sys_i,
    input  wire logic              sys_rst_i,
    input  wire dmd_pkg::dmd_mem_t mem_i,
    output logic [15:0]            mem_rdata_o
);
    int                  rd_cnt = 0, wr_cnt = 0, cyc = 0, rd_cyc = 0, wr_cyc = 0;
    dmd_pkg::dmd_target_t rd_tgt, wr_tgt;
    logic [3:0]          rd_sel;
    logic [15:0]         rd_addr, wr_addr, wr_data;
    logic [15:0]         held_ff = 16'h0000;
    logic                hold_ff = 1'b0;
    // each location reads a pattern of its target, select and offset
    function automatic logic [15:0] val(input dmd_pkg::dmd_mem_t m);
        return m.addr ^ 16'h5A5A ^ {m.tgt, m.sel, 8'h00};
    endfunction : val
    // data stands one cycle past the read, then inverts so stale capture shows
    assign mem_rdata_o = (mem_i.req && !mem_i.we) ? val(mem_i) : (hold_ff ? held_ff : ~held_ff);
    // record every access so the bench can judge decode and timing
    always @(posedge clk_sys_i) begin
        cyc <= cyc + 1;
        hold_ff <= !sys_rst_i && mem_i.req && !mem_i.we;
        if (mem_i.req && !mem_i.we) begin
            held_ff <= val(mem_i);
            rd_cnt <= rd_cnt + 1;
            rd_tgt <= mem_i.tgt;
            rd_sel <= mem_i.sel;
            rd_addr <= mem_i.addr;
            rd_cyc <= cyc;
        end
        if (mem_i.req && mem_i.we) begin
            wr_cnt <= wr_cnt + 1;
            wr_tgt <= mem_i.tgt;
            wr_addr <= mem_i.addr;
            wr_data <= mem_i.wdata;
            wr_cyc <= cyc;
        end
    end
endmodule : dmd_mem_model
`default_nettype wire

// ---- verif/dma_map_decode_and_timing_tb.sv ----
`timescale 1ns/100ps
`default_nettype none
module dma_map_decode_and_timing_tb;
    localparam int NCH = 6;
    logic              clk_sys_i, sys_rst_i, psel, penable, pwrite, pready, pslverr;
    logic [11:0]       paddr;
    logic [31:0]       pwdata, prdata, rdat;
    logic              rerr;
    dmd_pkg::dmd_mem_t mem;
    logic [15:0]       mem_rdata;
    logic [NCH-1:0]    done;
    int                failures = 0, n_checks = 0;
    int                seq[$];

    dmd_engine #(.NCH(NCH)) dmd_engine_inst (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .mem_o(mem), .mem_rdata_i(mem_rdata), .done_o(done));
    dmd_mem_model dmd_mem_model_inst (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .mem_i(mem),
        .mem_rdata_o(mem_rdata));

    // clock and a watchdog sized well past the whole sequence
    initial begin
        clk_sys_i = 1'b0;
        forever #4 clk_sys_i = ~clk_sys_i;
    end
    initial begin
        #(8 * 30000);
        failures++;
        finish_test();
    end
    // record which channel finished each element, in order
    always @(posedge clk_sys_i)
        for (int i = 0; i < NCH; i++)
            if (done[i] === 1'b1) seq.push_back(i);

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value at %0t: got %h, expected %h", $time, seen, exp);
        end
    endtask : chk
    // one apb transfer; waits on pready, never on a fixed count
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_sys_i);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys_i);
        penable <= 1'b1;
        do begin
            @(posedge clk_sys_i);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) failures++;
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic cfg(input int ch, input logic [1:0] ss, input logic [15:0] so, input logic [1:0] ds,
                       input logic [15:0] dof, input logic [15:0] cnt, input logic [2:0] flg);
        logic [11:0] b;
        b = 12'h100 + 12'(ch * 16);
        apb(1'b1, b + 12'h004, {16'h0000, so});
        apb(1'b1, b + 12'h008, {16'h0000, dof});
        apb(1'b1, b + 12'h00C, {16'h0000, cnt});
        apb(1'b1, b, {24'h00_0000, ds, ss, 1'b0, flg});
    endtask : cfg
    task automatic wait_done(input int ch);
        int n;
        n = 0;
        while (done[ch] !== 1'b1 && n < 300) begin
            @(posedge clk_sys_i);
            n++;
        end
        if (n >= 300) failures++;
        @(posedge clk_sys_i);
    endtask : wait_done
    task automatic regs;
        apb(1'b0, dmd_pkg::REG_SRC_PAGE, 32'h0000_0000);
        chk(rdat, 32'h0000_0000);
        apb(1'b1, dmd_pkg::REG_SRC_PAGE, 32'hFFFF_FFFF);
        apb(1'b0, dmd_pkg::REG_SRC_PAGE, 32'h0000_0000);
        chk(rdat, 32'h0000_007F);
        apb(1'b0, 12'h0FC, 32'h0000_0000);
        chk({rerr, rdat[30:0]}, 32'h8000_0000);
    endtask : regs
    // one element from the given source into data space; judges decode and phases
    task automatic run_one(input logic [1:0] ss, input logic [6:0] pg, input logic [15:0] so,
                           input dmd_pkg::dmd_target_t t, input logic [3:0] s);
        int          r;
        logic [15:0] v;
        r = dmd_mem_model_inst.rd_cnt;
        v = (t == dmd_pkg::TGT_RESERVED) ? 16'h0000 : (so ^ 16'h5A5A ^ {t, s, 8'h00});
        apb(1'b1, dmd_pkg::REG_SRC_PAGE, {25'h000_0000, pg});
        cfg(0, ss, so, 2'h1, 16'h1000, 16'h0001, 3'b001);
        wait_done(0);
        chk(dmd_mem_model_inst.rd_cnt - r, (t == dmd_pkg::TGT_RESERVED) ? 0 : 1);
        if (t != dmd_pkg::TGT_RESERVED) begin
            chk({dmd_mem_model_inst.rd_tgt, dmd_mem_model_inst.rd_sel, dmd_mem_model_inst.rd_addr}, {t, s, so});
            chk(dmd_mem_model_inst.wr_cyc - dmd_mem_model_inst.rd_cyc, 2);
        end
        chk({dmd_mem_model_inst.wr_tgt, dmd_mem_model_inst.wr_data}, {dmd_pkg::TGT_DUAL0, v});
    endtask : run_one
    // double word crossing the page end, then a reserved destination
    task automatic wrap_dword;
        int r, w;
        r = dmd_mem_model_inst.rd_cnt;
        w = dmd_mem_model_inst.wr_cnt;
        apb(1'b1, dmd_pkg::REG_SRC_PAGE, 32'h0000_0002);
        cfg(1, 2'h0, 16'hFFFF, 2'h1, 16'h2000, 16'h0001, 3'b101);
        wait_done(1);
        chk(dmd_mem_model_inst.rd_cnt - r, 1);
        chk(dmd_mem_model_inst.wr_cnt - w, 2);
        chk({dmd_mem_model_inst.wr_addr, dmd_mem_model_inst.wr_data}, 32'h2001_0000);
        w = dmd_mem_model_inst.wr_cnt;
        cfg(1, 2'h1, 16'h1000, 2'h3, 16'h0000, 16'h0002, 3'b001);
        wait_done(1);
        wait_done(1);
        chk(dmd_mem_model_inst.wr_cnt - w, 0);
    endtask : wrap_dword
    // two high and two low channels enabled close together
    task automatic arb;
        int ord[4] = '{1, 2, 0, 3};
        foreach (ord[i]) cfg(ord[i], 2'h1, 16'h1000, 2'h1, 16'h3000, 16'h0002, 3'b000);
        seq.delete();
        foreach (ord[i]) apb(1'b1, 12'h100 + 12'(ord[i] * 16), {24'h00_0000, 8'h51 | {6'h00, i < 2, 1'b0}});
        repeat (100) @(posedge clk_sys_i);
        chk(seq.size(), 8);
        for (int i = 0; i < 4; i++) chk(seq[i], (i % 2) ? 2 : 1);
        // low pair alternates once the high pair is drained
        chk(seq[4] + seq[5], 3);
        chk(seq[6], seq[4]);
        chk(seq[7], seq[5]);
    endtask : arb
    task automatic finish_test;
        $display("checks %0d, failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : finish_test

    initial begin
        sys_rst_i = 1'b1;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        repeat (12) @(posedge clk_sys_i);
        sys_rst_i <= 1'b0;
        regs();
        run_one(2'h0, 7'h00, 16'h001F, dmd_pkg::TGT_RESERVED, 4'h0);
        run_one(2'h0, 7'h00, 16'h0020, dmd_pkg::TGT_SERIAL, 4'h0);
        run_one(2'h0, 7'h00, 16'h0033, dmd_pkg::TGT_SERIAL, 4'hB);
        run_one(2'h0, 7'h00, 16'h0041, dmd_pkg::TGT_SERIAL, 4'h5);
        run_one(2'h0, 7'h00, 16'h0044, dmd_pkg::TGT_RESERVED, 4'h0);
        run_one(2'h0, 7'h00, 16'h0060, dmd_pkg::TGT_DUAL0, 4'h0);
        run_one(2'h0, 7'h00, 16'h8000, dmd_pkg::TGT_SINGLE2, 4'h0);
        run_one(2'h0, 7'h01, 16'h005F, dmd_pkg::TGT_RESERVED, 4'h0);
        run_one(2'h0, 7'h01, 16'h7FFF, dmd_pkg::TGT_SINGLE1, 4'h0);
        run_one(2'h0, 7'h01, 16'h8000, dmd_pkg::TGT_SINGLE3, 4'h0);
        run_one(2'h0, 7'h02, 16'hEFFF, dmd_pkg::TGT_RESERVED, 4'h0);
        run_one(2'h0, 7'h02, 16'hF000, dmd_pkg::TGT_SINGLE4, 4'h0);
        run_one(2'h0, 7'h03, 16'h8000, dmd_pkg::TGT_RESERVED, 4'h0);
        run_one(2'h1, 7'h03, 16'h0022, dmd_pkg::TGT_SERIAL, 4'h2);
        run_one(2'h1, 7'h00, 16'h002F, dmd_pkg::TGT_RESERVED, 4'h0);
        run_one(2'h1, 7'h00, 16'h007F, dmd_pkg::TGT_SCRATCH, 4'h0);
        run_one(2'h1, 7'h00, 16'h0080, dmd_pkg::TGT_DUAL0, 4'h0);
        run_one(2'h1, 7'h00, 16'hFFFF, dmd_pkg::TGT_SINGLE2, 4'h0);
        run_one(2'h2, 7'h00, 16'hFFFF, dmd_pkg::TGT_FIFO, 4'h0);
        run_one(2'h3, 7'h00, 16'h0040, dmd_pkg::TGT_RESERVED, 4'h0);
        wrap_dword();
        arb();
        finish_test();
    end
endmodule : dma_map_decode_and_timing_tb
`default_nettype wire
